// ==== design/audio_clock_source_selector.sv ====
// Audio clock source selector with lock, sync and period status.
`timescale 1ns/1ps
`include "clk_sel_consts.svh"
module audio_clock_source_selector (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Avalon-MM slave.
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Raw reference pins: word, AES, ADAT1, ADAT2.
  input  wire logic [3:0]  ref_in,
  // Host recording state, same clock domain.
  input  wire logic        record_active,
  // Clock control and status.
  output logic      [2:0]  clk_sel,
  output logic             master,
  output logic      [11:0] cur_period,
  output logic             rate_mismatch,
  output logic             monitor_route,
  output logic             irq
);
  function automatic logic near(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= 12'h001;
  endfunction

  clk_sel_pkg::av_req_t    req;
  clk_sel_pkg::ctrl_t      ctrl;
  clk_sel_pkg::ctrl_t      next_ctrl;
  clk_sel_pkg::sel_state_t state;
  clk_sel_pkg::sel_state_t next_state;
  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic [1:0]  src;
  logic [1:0]  next_src;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic [2:0]  left;
  logic [2:0]  next_left;
  logic [3:0]  irq_st;
  logic [3:0]  next_irq_st;
  logic [3:0]  irq_mask;
  logic [3:0]  next_irq_mask;
  logic [3:0]  ev;
  logic        next_mismatch;
  logic        next_monitor;
  logic        record_d;
  logic [3:0]  valid;
  logic [3:0]  synced;
  logic [7:0]  sts;
  logic [11:0] rep [4];
  logic [11:0] eff_period;
  logic        hit;
  logic        wr_acc;

  assign req = '{address: address, read: read, write: write,
                 writedata: writedata};

  // Per-input pin synchroniser, period counter and lock detector.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_in
      logic        s1;
      logic        s2;
      logic        s3;
      logic [11:0] cnt;
      logic [11:0] next_cnt;
      logic [11:0] per;
      logic [11:0] next_per;
      logic        lock;
      logic        next_lock;
      always_comb begin
        next_cnt  = cnt;
        next_per  = per;
        next_lock = lock;
        if (s2 && !s3) begin
          next_per  = cnt;
          next_lock = near(cnt, per) && (cnt >= `MIN_PER);
          next_cnt  = 12'h001;
        end else if (cnt == 12'(`LOSS_CYC)) begin
          next_lock = 1'b0;
          next_per  = 12'h000;
        end else begin
          next_cnt  = cnt + 12'h001;
        end
      end
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          s1   <= 1'b0;
          s2   <= 1'b0;
          s3   <= 1'b0;
          cnt  <= 12'h000;
          per  <= 12'h000;
          lock <= 1'b0;
        end else begin
          s1   <= ref_in[gi];
          s2   <= s1;
          s3   <= s2;
          cnt  <= next_cnt;
          per  <= next_per;
          lock <= next_lock;
        end
      end
      assign valid[gi]  = lock;
      assign rep[gi]    = lock ? per : 12'h000;
      assign synced[gi] = lock && near(per, eff_period);
      assign sts[2*gi+:2] = {synced[gi], lock};
    end
  endgenerate

  // Slave runs at the followed input's rate; host rate only when master.
  assign eff_period = (state == clk_sel_pkg::ST_FOLLOW) ? rep[src]
                                                        : ctrl.host_period;

  // Source selection.
  always_comb begin
    next_state = state;
    next_src   = src;
    next_idx   = idx;
    next_left  = left;
    ev         = 4'h0;
    case (state)
      clk_sel_pkg::ST_INT: begin
        if (ctrl.auto_en) begin
          next_state = clk_sel_pkg::ST_SCAN;
          next_idx   = ctrl.pref;
          next_left  = `SCAN_ALL;
        end
      end
      clk_sel_pkg::ST_SCAN: begin
        if (!ctrl.auto_en) begin
          next_state = clk_sel_pkg::ST_INT;
        end else if (valid[idx]) begin
          next_state = clk_sel_pkg::ST_FOLLOW;
          next_src   = idx;
          ev[`IRQ_SRC_CHG] = 1'b1;
        end else if (left == 3'h1) begin
          next_state = clk_sel_pkg::ST_INT;
        end else begin
          next_left = left - 3'h1;
          if (left == `SCAN_ALL) begin
            next_idx = (ctrl.pref == 2'h0) ? 2'h1 : 2'h0;
          end else if (idx + 2'h1 == ctrl.pref) begin
            next_idx = idx + 2'h2;
          end else begin
            next_idx = idx + 2'h1;
          end
        end
      end
      clk_sel_pkg::ST_FOLLOW: begin
        if (!ctrl.auto_en) begin
          next_state = clk_sel_pkg::ST_INT;
        end else if (!valid[src]) begin
          next_state = clk_sel_pkg::ST_INT;
          ev[`IRQ_REVERT] = 1'b1;
        end else if (src != ctrl.pref && valid[ctrl.pref]) begin
          next_src = ctrl.pref;
          ev[`IRQ_SRC_CHG] = 1'b1;
        end
      end
      default: begin
        next_state = clk_sel_pkg::ST_INT;
      end
    endcase
    next_mismatch = (state == clk_sel_pkg::ST_FOLLOW) &&
                    !near(ctrl.host_period, rep[src]);
    next_monitor  = ctrl.dm_en && record_active;
    ev[`IRQ_MISMATCH] = next_mismatch && !rate_mismatch;
    ev[`IRQ_RECORD]   = record_active && !record_d;
  end

  // Bus slave: one wait cycle, then the answer.
  assign hit    = (req.address == `OFS_CTRL) || (req.address == `OFS_STATUS)
               || (req.address == `OFS_PER01) || (req.address == `OFS_PER23)
               || (req.address == `OFS_CURPER) || (req.address == `OFS_IRQ_ST)
               || (req.address == `OFS_IRQ_MASK);
  assign wr_acc = req.write && ack;
  assign waitrequest = (req.read || req.write) && !ack;

  always_comb begin
    next_ack      = (req.read || req.write) && !ack;
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    next_irq_st   = irq_st | ev;
    next_readdata = readdata;
    if (wr_acc && req.address == `OFS_CTRL) begin
      next_ctrl = req.writedata[15:0];
    end
    if (wr_acc && req.address == `OFS_IRQ_MASK) begin
      next_irq_mask = req.writedata[3:0];
    end
    if (wr_acc && req.address == `OFS_IRQ_ST) begin
      next_irq_st = (irq_st & ~req.writedata[3:0]) | ev;
    end
    if (req.read && !ack) begin
      case (req.address)
        `OFS_CTRL:     next_readdata = {16'h0000, ctrl};
        `OFS_STATUS:   next_readdata = {19'h00000, rate_mismatch, master,
                                        clk_sel, sts};
        `OFS_PER01:    next_readdata = {4'h0, rep[1], 4'h0, rep[0]};
        `OFS_PER23:    next_readdata = {4'h0, rep[3], 4'h0, rep[2]};
        `OFS_CURPER:   next_readdata = {20'h00000, cur_period};
        `OFS_IRQ_ST:   next_readdata = {28'h0000000, irq_st};
        `OFS_IRQ_MASK: next_readdata = {28'h0000000, irq_mask};
        default:       next_readdata = hit ? readdata : 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state         <= clk_sel_pkg::ST_INT;
      src           <= 2'h0;
      idx           <= 2'h0;
      left          <= 3'h0;
      ack           <= 1'b0;
      ctrl          <= `CTRL_RST;
      irq_st        <= `IRQ_RST;
      irq_mask      <= `IRQ_RST;
      readdata      <= 32'h00000000;
      rate_mismatch <= 1'b0;
      monitor_route <= 1'b0;
      record_d      <= 1'b0;
      cur_period    <= 12'h000;
    end else begin
      state         <= next_state;
      src           <= next_src;
      idx           <= next_idx;
      left          <= next_left;
      ack           <= next_ack;
      ctrl          <= next_ctrl;
      irq_st        <= next_irq_st;
      irq_mask      <= next_irq_mask;
      readdata      <= next_readdata;
      rate_mismatch <= next_mismatch;
      monitor_route <= next_monitor;
      record_d      <= record_active;
      cur_period    <= eff_period;
    end
  end

  assign master  = (state != clk_sel_pkg::ST_FOLLOW);
  assign clk_sel = master ? 3'h0 : {1'b0, src} + 3'h1;
  assign irq     = |(irq_st & irq_mask);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_lost;
    state == clk_sel_pkg::ST_FOLLOW && ctrl.auto_en && !valid[src];
  endsequence
  sequence s_back_int;
    state == clk_sel_pkg::ST_INT && irq_st[`IRQ_REVERT] && master;
  endsequence

  property p_scan_start;
    state == clk_sel_pkg::ST_INT && ctrl.auto_en
      |=> state == clk_sel_pkg::ST_SCAN;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("no scan");

  property p_adopt;
    state == clk_sel_pkg::ST_SCAN && ctrl.auto_en && valid[idx]
      |=> state == clk_sel_pkg::ST_FOLLOW && src == $past(idx) && !master;
  endproperty
  a_adopt: assert property (p_adopt) else $error("valid input ignored");

  property p_revert;
    s_lost |=> s_back_int ##1 state == clk_sel_pkg::ST_SCAN;
  endproperty
  a_revert: assert property (p_revert) else $error("no reversion");

  property p_sync_needs_lock;
    (synced & ~valid) == 4'h0;
  endproperty
  a_sync_needs_lock: assert property (p_sync_needs_lock)
    else $error("sync without lock");

  property p_prefer;
    state == clk_sel_pkg::ST_FOLLOW && ctrl.auto_en && valid[src]
      && valid[ctrl.pref] && $stable(ctrl) |=> src == $past(ctrl.pref);
  endproperty
  a_prefer: assert property (p_prefer) else $error("preferred unused");

  property p_none_valid;
    state == clk_sel_pkg::ST_SCAN && ctrl.auto_en && !valid[idx]
      && left == 3'h1 |=> state == clk_sel_pkg::ST_INT && clk_sel == 3'h0;
  endproperty
  a_none_valid: assert property (p_none_valid) else $error("no fallback");

  property p_skip_pref;
    state == clk_sel_pkg::ST_SCAN && ctrl.auto_en && !valid[idx]
      && left > 3'h1 && $stable(ctrl) |=> idx != ctrl.pref;
  endproperty
  a_skip_pref: assert property (p_skip_pref) else $error("bad order");

  property p_nolock_zero;
    (valid[0] || rep[0] == 12'h000) && (valid[1] || rep[1] == 12'h000)
      && (valid[2] || rep[2] == 12'h000) && (valid[3] || rep[3] == 12'h000);
  endproperty
  a_nolock_zero: assert property (p_nolock_zero)
    else $error("period without lock");

  property p_slave_rate;
    state == clk_sel_pkg::ST_FOLLOW && $stable(src)
      |=> cur_period == $past(rep[src]);
  endproperty
  a_slave_rate: assert property (p_slave_rate) else $error("host rate");

  property p_mismatch;
    state == clk_sel_pkg::ST_FOLLOW && !near(ctrl.host_period, rep[src])
      |=> rate_mismatch && (irq_st[`IRQ_MISMATCH] || $past(rate_mismatch));
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("no mismatch");

  property p_monitor;
    ctrl.dm_en && record_active |=> monitor_route;
  endproperty
  a_monitor: assert property (p_monitor) else $error("no monitoring");
endmodule // audio_clock_source_selector

// ==== shared/clk_sel_consts.svh ====
// Offsets, reset values and timing counts of the audio clock source selector.
`ifndef CLK_SEL_CONSTS_SVH
`define CLK_SEL_CONSTS_SVH
`define OFS_CTRL     5'h00
`define OFS_STATUS   5'h04
`define OFS_PER01    5'h08
`define OFS_PER23    5'h0c
`define OFS_CURPER   5'h10
`define OFS_IRQ_ST   5'h14
`define OFS_IRQ_MASK 5'h18
`define CTRL_RST     16'h0000
`define IRQ_RST      4'h0
`define IRQ_SRC_CHG  0
`define IRQ_REVERT   1
`define IRQ_MISMATCH 2
`define IRQ_RECORD   3
`define CLK_NS       50
`define LOSS_NS      100000
`define LOSS_CYC     (`LOSS_NS / `CLK_NS)
`define MIN_PER      12'h002
`define SCAN_ALL     3'h4
`endif

// ==== shared/clk_sel_pkg.sv ====
// Types shared by the audio clock source selector.
package clk_sel_pkg;
  typedef enum logic [2:0] {
    ST_INT    = 3'b001,
    ST_SCAN   = 3'b010,
    ST_FOLLOW = 3'b100
  } sel_state_t;
  typedef struct packed {
    logic [11:0] host_period;
    logic        dm_en;
    logic [1:0]  pref;
    logic        auto_en;
  } ctrl_t;
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } av_req_t;
endpackage

// ==== testbench/ref_clock_source.sv ====
// Far-side equipment model that feeds free-running reference clocks.
`timescale 1ns/1ps
module ref_clock_source #(
  parameter int HALF_NS      = 200,
  parameter int SLOW_HALF_NS = 300
) (
  // Lane enables from the bench.
  input  wire logic [3:0] en,
  // Reference pins: word, AES, ADAT1, ADAT2.
  output logic      [3:0] ref_in
);
  for (genvar i = 0; i < 4; i++) begin : g_lane
    logic lane;
    assign ref_in[i] = lane;
    // The equipment only sources a clock and never follows this block.
    initial begin
      lane = 1'b0;
      #(7 + 13 * i);
      forever begin
        #((i == 3) ? SLOW_HALF_NS : HALF_NS);
        // A switched-off source leaves its line idle low.
        lane = en[i] ? ~lane : 1'b0;
      end
    end
  end
endmodule // ref_clock_source

// ==== testbench/audio_clock_source_selector_tb_top.sv ====
// Self-checking bench for the audio clock source selector.
`timescale 1ns/1ps
`include "clk_sel_consts.svh"
module audio_clock_source_selector_tb_top;
  logic        core_clk;
  logic        rstn;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  ref_in;
  logic [3:0]  en;
  logic        record_active;
  logic [2:0]  clk_sel;
  logic        master;
  logic [11:0] cur_period;
  logic        rate_mismatch;
  logic        monitor_route;
  logic        irq;
  int          err_total;
  int          samples_checked;
  int          cyc;
  logic [31:0] rd;

  audio_clock_source_selector DUT (.core_clk(core_clk), .rstn(rstn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ref_in(ref_in),
    .record_active(record_active), .clk_sel(clk_sel), .master(master),
    .cur_period(cur_period), .rate_mismatch(rate_mismatch),
    .monitor_route(monitor_route), .irq(irq));
  ref_clock_source far (.en(en), .ref_in(ref_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hangs are cut short well after the longest expected loss wait.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(logic wr, logic [4:0] a, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0);
    rd = readdata;
    chk("wait cycles", 32'h2, 32'(n));
    read <= 1'b0;
    write <= 1'b0;
  endtask

  function automatic logic [31:0] cw(logic [11:0] hp, logic dm,
                                      logic [1:0] pf, logic au);
    clk_sel_pkg::ctrl_t c;
    c = '{hp, dm, pf, au};
    return {16'h0000, c};
  endfunction

  task automatic wait_sel(logic [2:0] exp, int lim);
    int n;
    n = 0;
    while (clk_sel !== exp && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk("clk_sel", 32'(exp), 32'(clk_sel));
  endtask

  task automatic s_reset;
    chk("master", 32'h1, 32'(master));
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    bus(1'b0, 5'h1c, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, `OFS_STATUS, 32'hffff_ffff);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("status", 32'h0000_0800, rd);
  endtask

  task automatic s_fallback;
    bus(1'b1, `OFS_CTRL, cw(12'h008, 1'b0, 2'h0, 1'b1));
    repeat (40) @(negedge core_clk);
    chk("idle sel", 32'h0, 32'(clk_sel));
    en <= 4'b1100;
    wait_sel(3'h3, 300);
    chk("master", 32'h0, 32'(master));
    chk("period", 32'h8, 32'(cur_period));
    // The slower second ADAT lane locks some cycles after the first one.
    repeat (20) @(negedge core_clk);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("status", 32'h0000_0370, rd);
    bus(1'b0, `OFS_PER01, 32'h0);
    chk("per01", 32'h0, rd);
    bus(1'b0, `OFS_PER23, 32'h0);
    chk("per23", 32'h000c_0008, rd);
  endtask

  task automatic s_order;
    bus(1'b1, `OFS_CTRL, cw(12'h008, 1'b0, 2'h0, 1'b0));
    wait_sel(3'h0, 50);
    en <= 4'b1110;
    repeat (100) @(negedge core_clk);
    bus(1'b1, `OFS_IRQ_ST, 32'hf);
    bus(1'b1, `OFS_CTRL, cw(12'h008, 1'b0, 2'h0, 1'b1));
    wait_sel(3'h2, 50);
    bus(1'b0, `OFS_IRQ_ST, 32'h0);
    chk("irq adopt", 32'h1, 32'(rd[`IRQ_SRC_CHG]));
    en <= 4'b1111;
    wait_sel(3'h1, 300);
  endtask

  task automatic s_mismatch;
    chk("mismatch", 32'h0, 32'(rate_mismatch));
    bus(1'b1, `OFS_IRQ_ST, 32'hf);
    bus(1'b1, `OFS_CTRL, cw(12'h014, 1'b0, 2'h0, 1'b1));
    repeat (3) @(negedge core_clk);
    chk("mismatch", 32'h1, 32'(rate_mismatch));
    chk("period", 32'h8, 32'(cur_period));
    chk("irq masked", 32'h0, 32'(irq));
    bus(1'b1, `OFS_IRQ_MASK, 32'h4);
    bus(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk("mask", 32'h4, rd);
    @(negedge core_clk);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, `OFS_IRQ_ST, 32'h4);
    @(negedge core_clk);
    chk("irq clr", 32'h0, 32'(irq));
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
  endtask

  task automatic s_loss;
    bus(1'b1, `OFS_IRQ_ST, 32'hf);
    en <= 4'b0000;
    wait_sel(3'h0, `LOSS_CYC + 400);
    repeat (3) @(negedge core_clk);
    chk("master", 32'h1, 32'(master));
    chk("period", 32'h14, 32'(cur_period));
    chk("mismatch", 32'h0, 32'(rate_mismatch));
    bus(1'b0, `OFS_IRQ_ST, 32'h0);
    chk("irq revert", 32'h1, 32'(rd[`IRQ_REVERT]));
  endtask

  task automatic s_monitor;
    bus(1'b1, `OFS_CTRL, cw(12'h014, 1'b1, 2'h0, 1'b0));
    @(posedge core_clk);
    record_active <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("monitor", 32'h1, 32'(monitor_route));
    bus(1'b0, `OFS_IRQ_ST, 32'h0);
    chk("irq rec", 32'h1, 32'(rd[`IRQ_RECORD]));
    bus(1'b1, `OFS_CTRL, cw(12'h014, 1'b0, 2'h0, 1'b0));
    repeat (2) @(negedge core_clk);
    chk("monitor off", 32'h0, 32'(monitor_route));
  endtask

  initial begin
    err_total = 0;
    samples_checked = 0;
    rstn = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    en = 4'b0000;
    record_active = 1'b0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    s_reset();
    s_fallback();
    s_order();
    s_mismatch();
    s_loss();
    s_monitor();
    finish_test();
  end
endmodule // audio_clock_source_selector_tb_top
